// [hdl/cshp_pkg.sv]
// Constants shared by the card SPI host port and its link-side shifter.
// Assumes an 8-bit CPU bus with 16-bit addresses and a 12 ns link clock.
package cshp_pkg;

  // ----------------------------------------------------------------------
  // Register addresses on the CPU bus
  // ----------------------------------------------------------------------
  localparam logic [15:0] ADDR_XFER = 16'hDF10; // spi_transfer_data
  localparam logic [15:0] ADDR_CTL  = 16'hDF11; // card_interface_control
  localparam logic [15:0] ADDR_STAT = 16'hDF12; // card_interface_status

  // ----------------------------------------------------------------------
  // Control field positions and reset value
  // ----------------------------------------------------------------------
  localparam int unsigned CTL_IF_DIS   = 7; // interface_disable
  localparam int unsigned CTL_TRIG_RD  = 6; // 1: start on read
  localparam int unsigned CTL_EXT_ROM  = 5;
  localparam int unsigned CTL_SEL_HI   = 4;
  localparam int unsigned CTL_FAST     = 2; // 1: fast clock
  localparam int unsigned CTL_SEL_LO   = 1; // target select code, low bit
  localparam int unsigned CTL_BOOT_DIS = 0; // boot_rom_disable
  localparam logic [7:0]  CTL_RST      = 8'h02;

  // Target select codes from {bit 4, bit 1}
  localparam logic [1:0] SEL_CARD  = 2'h0;
  localparam logic [1:0] SEL_NONE  = 2'h1;
  localparam logic [1:0] SEL_FLASH = 2'h2;
  localparam logic [1:0] SEL_RTC   = 2'h3;

  // ----------------------------------------------------------------------
  // Link timing
  // ----------------------------------------------------------------------
  localparam int unsigned LCLK_PERIOD_PS = 12000;
  localparam int unsigned SLOW_SCK_KHZ   = 250;
  localparam int unsigned FAST_SCK_KHZ   = 8000;
  localparam int unsigned SLOW_HALF_PS   = 1000000000 / (2 * SLOW_SCK_KHZ);
  localparam int unsigned FAST_HALF_PS   = 1000000000 / (2 * FAST_SCK_KHZ);
  // Half periods are least times: round up so the rate is never exceeded
  localparam int unsigned SLOW_HALF_CYC  =
    (SLOW_HALF_PS + LCLK_PERIOD_PS - 1) / LCLK_PERIOD_PS;
  localparam int unsigned FAST_HALF_CYC  =
    (FAST_HALF_PS + LCLK_PERIOD_PS - 1) / LCLK_PERIOD_PS;
  localparam logic [7:0]  SLOW_HALF_LD   = 8'(SLOW_HALF_CYC - 1);
  localparam logic [7:0]  FAST_HALF_LD   = 8'(FAST_HALF_CYC - 1);
  localparam logic [2:0]  LAST_BIT       = 3'h7;

  typedef enum logic [1:0] {
    CSHP_IDLE  = 2'b01,
    CSHP_SHIFT = 2'b10
  } cshp_state_t;

endpackage

// [hdl/cshp_shifter.sv]
// Link-side byte shifter of the card SPI host port, mode 0, MSB first.
// Runs on the link clock; start arrives as a toggle from the CPU domain,
// completion goes back as a toggle. The byte is held stable by the CPU side
// while a transfer runs; the rate is latched here at the start.
`timescale 1ns/1ps
module cshp_shifter import cshp_pkg::*; (
  input  wire logic       lclk,      // Link clock
  input  wire logic       rst_b,     // CPU-domain reset, synchronised here
  input  wire logic       start_tgl, // Toggles once per transfer request
  input  wire logic [7:0] tx_byte,   // Byte to send, stable while busy
  input  wire logic       fast,      // Rate select, latched at transfer start
  input  wire logic       miso,      // Serial data from target (pin)
  output logic            sck,       // Serial clock, idles low
  output logic            mosi,      // Serial data to target
  output logic            done_tgl,  // Toggles when a byte is complete
  output logic [7:0]      rx_byte    // Last received byte
);

  logic [1:0]  rst_sync_ff;
  logic [2:0]  st_sync_ff;
  logic [1:0]  miso_sync_ff;
  cshp_state_t state_ff;
  logic [7:0]  half_ff;
  logic [2:0]  bit_ff;
  logic [7:0]  shreg_ff;
  logic [7:0]  rx_ff;
  logic        sck_ff;
  logic        mosi_ff;
  logic        samp_ff;
  logic        fast_ff;
  logic        done_ff;

  wire        lrst_b  = rst_sync_ff[1];
  wire        go      = st_sync_ff[2] ^ st_sync_ff[1];
  wire        tick    = (half_ff == 8'h00);
  wire [7:0]  half_ld = fast_ff ? FAST_HALF_LD : SLOW_HALF_LD;
  wire [7:0]  half_go = fast ? FAST_HALF_LD : SLOW_HALF_LD;
  wire [7:0]  nxt_shreg = {shreg_ff[6:0], samp_ff};

  // ----------------------------------------------------------------------
  // Crossings into the link domain
  // ----------------------------------------------------------------------
  always_ff @(posedge lclk) begin
    rst_sync_ff <= {rst_sync_ff[0], rst_b};
  end

  always_ff @(posedge lclk) begin
    if (!lrst_b) begin
      st_sync_ff   <= 3'h0;
      miso_sync_ff <= 2'h0;
    end else begin
      st_sync_ff   <= {st_sync_ff[1:0], start_tgl};
      miso_sync_ff <= {miso_sync_ff[0], miso};
    end
  end

  // ----------------------------------------------------------------------
  // Full-duplex shifter: sample on rising edge, shift on falling edge
  // ----------------------------------------------------------------------
  always_ff @(posedge lclk) begin
    if (!lrst_b) begin
      state_ff <= CSHP_IDLE;
      half_ff  <= 8'h00;
      bit_ff   <= 3'h0;
      shreg_ff <= 8'h00;
      rx_ff    <= 8'h00;
      sck_ff   <= 1'b0;
      mosi_ff  <= 1'b0;
      samp_ff  <= 1'b0;
      fast_ff  <= 1'b0;
      done_ff  <= 1'b0;
    end else begin
      unique case (state_ff)
        CSHP_IDLE: begin
          if (go) begin
            state_ff <= CSHP_SHIFT;
            shreg_ff <= tx_byte;
            mosi_ff  <= tx_byte[7];
            bit_ff   <= 3'h0;
            fast_ff  <= fast;
            half_ff  <= half_go;
          end
        end
        CSHP_SHIFT: begin
          if (!tick) begin
            half_ff <= half_ff - 8'h01;
          end else begin
            half_ff <= half_ld;
            sck_ff  <= ~sck_ff;
            if (!sck_ff) begin
              samp_ff <= miso_sync_ff[1];
            end else begin
              shreg_ff <= nxt_shreg;
              mosi_ff  <= shreg_ff[6];
              bit_ff   <= bit_ff + 3'h1;
              if (bit_ff == LAST_BIT) begin
                state_ff <= CSHP_IDLE;
                rx_ff    <= nxt_shreg;
                done_ff  <= ~done_ff;
              end
            end
          end
        end
      endcase
    end
  end

  assign sck      = sck_ff;
  assign mosi     = mosi_ff;
  assign done_tgl = done_ff;
  assign rx_byte  = rx_ff;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_sck_idle_low: assert property (@(posedge lclk) disable iff (!lrst_b)
    state_ff == CSHP_IDLE |-> !sck_ff)
    else $error("serial clock not low while idle");

  a_fast_half_len: assert property (@(posedge lclk) disable iff (!lrst_b)
    (state_ff == CSHP_SHIFT && fast_ff && $rose(sck_ff))
      |-> sck_ff [*6] ##1 !sck_ff)
    else $error("fast serial clock half period wrong");

endmodule

// [hdl/cshp_port.sv]
// Card SPI host port: three CPU registers, target selects and ROM map
// controls on mclk; byte shifting on the link clock in cshp_shifter.
// Assumes one-cycle cpu_wr/cpu_rd strobes synchronous to mclk, and card
// status pins arriving asynchronously.
//
// Notes on behaviour
// - Write sends byte; read returns last received.
// - Bit 6 picks write or read start.
// - Bit 7 disables; change only when boot off.
// - Bit 5 maps external ROM, boot off.
// - Status bit 0 busy, slow rate only.
// - Bits 4 and 1 pick card/flash/clock.
// - Bit 2 picks slow or fast clock.
`timescale 1ns/1ps
module cshp_port import cshp_pkg::*; (
  input  wire logic        mclk,          // System clock, 250 MHz
  input  wire logic        rst_b,         // Synchronous reset, active low
  input  wire logic [15:0] cpu_addr,      // CPU address
  input  wire logic [7:0]  cpu_wdata,     // CPU write data
  input  wire logic        cpu_wr,        // Write strobe, one cycle
  input  wire logic        cpu_rd,        // Read strobe, one cycle
  output logic      [7:0]  cpu_rdata,     // Read data, valid after strobe
  input  wire logic        lclk,          // Link clock
  output logic             spi_sck,       // Serial clock
  output logic             spi_mosi,      // Serial data out
  input  wire logic        spi_miso,      // Serial data in
  output logic             card_cs_b,     // Memory card select
  output logic             flash_cs_b,    // serial_flash_target select
  output logic             rtc_cs_b,      // Real-time clock select
  input  wire logic        card_wp,       // Card write protect pin
  input  wire logic        card_detect_b, // Low when card inserted
  input  wire logic        ext_exrom,     // External EXROM line
  input  wire logic        ext_game,      // External GAME line
  output logic             boot_rom_en,   // Own boot ROM mapped
  output logic             ext_rom_en     // External ROM mapped
);

  logic [7:0] ctl_ff;
  logic [7:0] tx_ff;
  logic [7:0] rx_ff;
  logic [7:0] rdata_ff;
  logic       busy_ff;
  logic       start_ff;
  logic [2:0] dn_sync_ff;
  logic [3:0] pin_s1_ff;
  logic [3:0] pin_s2_ff;
  logic       card_cs_b_ff;
  logic       flash_cs_b_ff;
  logic       rtc_cs_b_ff;
  logic       boot_rom_en_ff;
  logic       ext_rom_en_ff;
  logic       lk_done;
  logic [7:0] lk_rx;

  // ----------------------------------------------------------------------
  // Address decode and trigger
  // ----------------------------------------------------------------------
  wire       sel_xfer = (cpu_addr == ADDR_XFER);
  wire       sel_ctl  = (cpu_addr == ADDR_CTL);
  wire       sel_stat = (cpu_addr == ADDR_STAT);
  wire       wr_xfer  = cpu_wr & sel_xfer;
  wire       rd_xfer  = cpu_rd & sel_xfer;
  wire       wr_ctl   = cpu_wr & sel_ctl;
  wire       enabled  = ~ctl_ff[CTL_IF_DIS];
  wire       trig_src = ctl_ff[CTL_TRIG_RD] ? rd_xfer : wr_xfer;
  // Requests while busy are dropped so the held byte stays stable
  wire       trig     = enabled & ~busy_ff & trig_src;
  wire       done_evt = dn_sync_ff[2] ^ dn_sync_ff[1];
  wire       nxt_busy = trig | (busy_ff & ~done_evt);

  // Bit 7 only moves while the boot ROM is switched off
  wire       dis_bit  = ctl_ff[CTL_BOOT_DIS] ? cpu_wdata[CTL_IF_DIS]
                                             : ctl_ff[CTL_IF_DIS];
  wire [7:0] nxt_ctl  = wr_ctl ? {dis_bit, cpu_wdata[6:0]} : ctl_ff;

  wire [1:0] tsel     = {ctl_ff[CTL_SEL_HI], ctl_ff[CTL_SEL_LO]};
  // Busy is only reported at the slow rate
  wire       stat_busy = busy_ff & ~ctl_ff[CTL_FAST];
  wire [7:0] stat_val = {3'h0, pin_s2_ff, stat_busy};
  wire [7:0] rd_mux   = sel_xfer ? rx_ff :
                        sel_ctl  ? ctl_ff :
                        sel_stat ? stat_val : 8'h00;

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      ctl_ff   <= CTL_RST;
      tx_ff    <= 8'h00;
      rdata_ff <= 8'h00;
      busy_ff  <= 1'b0;
      start_ff <= 1'b0;
    end else begin
      ctl_ff   <= nxt_ctl;
      busy_ff  <= nxt_busy;
      start_ff <= start_ff ^ trig;
      if (wr_xfer && !busy_ff) begin
        tx_ff <= cpu_wdata;
      end
      if (cpu_rd) begin
        rdata_ff <= rd_mux;
      end
    end
  end

  // A write-started exchange sends the byte written in that same access
  wire [7:0] tx_send = tx_ff;

  // ----------------------------------------------------------------------
  // Return path from the link domain and pin synchronisers
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      dn_sync_ff <= 3'h0;
      pin_s1_ff  <= 4'h0;
      pin_s2_ff  <= 4'h0;
      rx_ff      <= 8'h00;
    end else begin
      dn_sync_ff <= {dn_sync_ff[1:0], lk_done};
      pin_s1_ff  <= {card_wp, card_detect_b, ext_exrom, ext_game};
      pin_s2_ff  <= pin_s1_ff;
      if (done_evt) begin
        rx_ff <= lk_rx;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Selects and ROM map
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      card_cs_b_ff   <= 1'b1;
      flash_cs_b_ff  <= 1'b1;
      rtc_cs_b_ff    <= 1'b1;
      boot_rom_en_ff <= 1'b0;
      ext_rom_en_ff  <= 1'b0;
    end else begin
      card_cs_b_ff   <= ~(enabled & (tsel == SEL_CARD));
      flash_cs_b_ff  <= ~(enabled & (tsel == SEL_FLASH));
      rtc_cs_b_ff    <= ~(enabled & (tsel == SEL_RTC));
      boot_rom_en_ff <= enabled & ~ctl_ff[CTL_BOOT_DIS];
      ext_rom_en_ff  <= enabled & ctl_ff[CTL_BOOT_DIS]
                        & ctl_ff[CTL_EXT_ROM];
    end
  end

  cshp_shifter u_shifter (
    .lclk      (lclk),
    .rst_b     (rst_b),
    .start_tgl (start_ff),
    .tx_byte   (tx_send),
    .fast      (ctl_ff[CTL_FAST]),
    .miso      (spi_miso),
    .sck       (spi_sck),
    .mosi      (spi_mosi),
    .done_tgl  (lk_done),
    .rx_byte   (lk_rx)
  );

  assign cpu_rdata   = rdata_ff;
  assign card_cs_b   = card_cs_b_ff;
  assign flash_cs_b  = flash_cs_b_ff;
  assign rtc_cs_b    = rtc_cs_b_ff;
  assign boot_rom_en = boot_rom_en_ff;
  assign ext_rom_en  = ext_rom_en_ff;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_write_start: assert property (@(posedge mclk) disable iff (!rst_b)
    (wr_xfer && !ctl_ff[CTL_TRIG_RD] && enabled && !busy_ff)
      |=> $changed(start_ff) && busy_ff)
    else $error("write did not start a transfer");

  a_read_start: assert property (@(posedge mclk) disable iff (!rst_b)
    (rd_xfer && ctl_ff[CTL_TRIG_RD] && enabled && !busy_ff)
      |=> $changed(start_ff) && busy_ff)
    else $error("read did not start a transfer");

  a_wrong_trig: assert property (@(posedge mclk) disable iff (!rst_b)
    (ctl_ff[CTL_TRIG_RD] && !cpu_rd) |=> $stable(start_ff))
    else $error("transfer started without a read");

  a_disabled_idle: assert property (@(posedge mclk) disable iff (!rst_b)
    ctl_ff[CTL_IF_DIS] |=> $stable(start_ff) && card_cs_b && rtc_cs_b)
    else $error("disabled interface still active");

  a_dis_guard: assert property (@(posedge mclk) disable iff (!rst_b)
    (wr_ctl && !ctl_ff[CTL_BOOT_DIS]) |=> $stable(ctl_ff[CTL_IF_DIS]))
    else $error("disable bit changed while boot ROM on");

  a_ext_rom_map: assert property (@(posedge mclk) disable iff (!rst_b)
    ##1 ext_rom_en == $past(enabled & ctl_ff[CTL_BOOT_DIS]
                            & ctl_ff[CTL_EXT_ROM]))
    else $error("external ROM map wrong");

  a_busy_slow: assert property (@(posedge mclk) disable iff (!rst_b)
    (cpu_rd && sel_stat)
      |=> cpu_rdata[0] == ($past(busy_ff) && !$past(ctl_ff[CTL_FAST])))
    else $error("busy status wrong for rate");

  a_rtc_select: assert property (@(posedge mclk) disable iff (!rst_b)
    (enabled && tsel == SEL_RTC) |=> !rtc_cs_b && card_cs_b && flash_cs_b)
    else $error("clock target not selected alone");

  a_rx_on_done: assert property (@(posedge mclk) disable iff (!rst_b)
    done_evt |=> rx_ff == $past(lk_rx) && !busy_ff)
    else $error("received byte not captured");

  c_write_xfer: cover property (@(posedge mclk) disable iff (!rst_b)
    trig && !ctl_ff[CTL_TRIG_RD]);
  c_read_xfer: cover property (@(posedge mclk) disable iff (!rst_b)
    trig && ctl_ff[CTL_TRIG_RD]);
  c_rtc_done: cover property (@(posedge mclk) disable iff (!rst_b)
    done_evt && tsel == SEL_RTC);
  c_fast_done: cover property (@(posedge mclk) disable iff (!rst_b)
    done_evt && ctl_ff[CTL_FAST]);

endmodule

// [tb/cshp_spi_target.sv]
// SPI target model standing for the memory card, flash and clock chip.
// Assumes mode 0, MSB first, reply byte set before each transfer.
`timescale 1ns/1ps
module cshp_spi_target (
  input  wire logic       sck,   // Serial clock from host
  input  wire logic       mosi,  // Serial data from host
  input  wire logic       sel_b, // Low while any target is selected
  input  wire logic [7:0] reply, // Byte sent back to the host
  output logic            miso,  // Serial data to host
  output logic [7:0]      got    // Bits taken from mosi
);
  logic [2:0] nfall = 3'h0;
  logic       bit_o;

  assign bit_o = reply[3'h7 - nfall];
  // No pull on the line: a released target shows the inverse bit so
  // a stale value can never pass for a good one
  assign miso = sel_b ? ~bit_o : bit_o;

  always @(posedge sck) got <= {got[6:0], mosi};
  // Bit count restarts while nothing is selected, so the clock settling
  // out of reset is never counted as a shifted bit
  always @(negedge sck or posedge sel_b) begin
    if (sel_b) begin
      nfall <= 3'h0;
    end else begin
      nfall <= nfall + 3'h1;
    end
  end
endmodule

// [tb/card_spi_host_port_tb.sv]
// Self-checking bench for the card SPI host port and one SPI target.
// Assumes the register map and control layout of cshp_pkg.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); \
  n_mismatch++; end end
module card_spi_host_port_tb import cshp_pkg::*;;
  localparam logic [7:0] CTL_TAB [6] =
    '{8'h00, 8'h04, 8'h14, 8'h12, 8'h40, 8'h54};
  logic        mclk;
  logic        lclk;
  logic        rst_b;
  logic        cpu_wr;
  logic        cpu_rd;
  logic [15:0] cpu_addr;
  logic [7:0]  cpu_wdata;
  logic [7:0]  rdata;
  logic [7:0]  reply;
  logic [7:0]  got;
  logic        sck, mosi, miso, wp, det_b, exrom, game, boot_en, ext_en;
  logic        card_cs_b, flash_cs_b, rtc_cs_b;
  logic [31:0] seed = 32'h2c99_53a5;
  int          n_mismatch = 0;
  int          compares = 0;

  initial begin
    mclk = 1'h0;
    forever #2 mclk = ~mclk;
  end
  // Link clock runs free and out of phase with mclk
  initial begin
    lclk = 1'h0;
    #1.7;
    forever #6 lclk = ~lclk;
  end

  cshp_port i_dut (.mclk(mclk), .rst_b(rst_b), .cpu_addr(cpu_addr),
    .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
    .cpu_rdata(rdata), .lclk(lclk), .spi_sck(sck), .spi_mosi(mosi),
    .spi_miso(miso), .card_cs_b(card_cs_b), .flash_cs_b(flash_cs_b),
    .rtc_cs_b(rtc_cs_b), .card_wp(wp), .card_detect_b(det_b),
    .ext_exrom(exrom), .ext_game(game), .boot_rom_en(boot_en),
    .ext_rom_en(ext_en));
  cshp_spi_target i_tgt (.sck(sck), .mosi(mosi),
    .sel_b(card_cs_b & flash_cs_b & rtc_cs_b), .reply(reply),
    .miso(miso), .got(got));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Expected {rtc, flash, card} selects for a control value
  function automatic logic [2:0] exp_cs(input logic [7:0] c);
    logic [1:0] s;
    s = {c[CTL_SEL_HI], c[CTL_SEL_LO]};
    return {s != SEL_RTC, s != SEL_FLASH, s != SEL_CARD} | {3{c[7]}};
  endfunction

  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge mclk);
    cpu_addr = a;
    cpu_wdata = d;
    cpu_wr = 1'h1;
    @(negedge mclk);
    cpu_wr = 1'h0;
  endtask

  // Sampled one and a half cycles after the answer edge, so it has settled
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge mclk);
    cpu_addr = a;
    cpu_rd = 1'h1;
    @(negedge mclk);
    cpu_rd = 1'h0;
    @(negedge mclk);
    d = rdata;
  endtask

  // One byte exchange under control value c, sending d
  task automatic xfer(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] v;
    logic [7:0] r;
    int         k;
    r = 8'(xs());
    reply = r;
    wr(ADDR_CTL, c);
    repeat (4) @(negedge lclk);
    wr(ADDR_XFER, d);
    if (c[CTL_TRIG_RD]) begin
      rd(ADDR_STAT, v);
      `CHK("start on write", 1'h0, v[0])
      rd(ADDR_XFER, v);
    end
    rd(ADDR_STAT, v);
    `CHK("busy flag", !c[CTL_FAST], v[0])
    wr(ADDR_XFER, ~d);
    if (c[CTL_FAST]) begin
      repeat (800) @(negedge mclk);
    end else begin
      k = 0;
      do begin
        rd(ADDR_STAT, v);
        k++;
      end while (v[0] && k < 5000);
      if (v[0]) begin
        n_mismatch++;
        $display("CHECK FAILED busy wait expected 0 seen 1");
      end
    end
    // Back to write start so reading the result starts nothing
    wr(ADDR_CTL, c & 8'hbf);
    rd(ADDR_XFER, v);
    `CHK("received byte", r, v)
    `CHK("sent byte", d, got)
    $display("test transfer %h done", c);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] v;
    cpu_addr = ADDR_XFER;
    cpu_wdata = 8'h00;
    cpu_wr = 1'h0;
    cpu_rd = 1'h0;
    rst_b = 1'h0;
    reply = 8'h00;
    {wp, det_b, exrom, game} = 4'h5;
    repeat (16) @(negedge mclk);
    rst_b = 1'h1;
    rd(ADDR_CTL, v);
    `CHK("control reset", CTL_RST, v)
    `CHK("boot rom", 2'b10, {boot_en, ext_en})
    `CHK("reset selects", 3'h7, {rtc_cs_b, flash_cs_b, card_cs_b})
    {wp, det_b, exrom, game} = 4'(xs());
    wr(ADDR_STAT, 8'hff);
    rd(ADDR_STAT, v);
    `CHK("status", {3'h0, wp, det_b, exrom, game, 1'h0}, v)
    rd(16'hdf13, v);
    `CHK("unmapped", 8'h00, v)
    $display("test reset done");

    for (int s = 0; s < 4; s++) begin
      v = {3'h0, s[1], 2'h0, s[0], 1'h0};
      wr(ADDR_CTL, v);
      @(negedge mclk);
      `CHK("selects", exp_cs(v), {rtc_cs_b, flash_cs_b, card_cs_b})
    end
    $display("test selects done");

    foreach (CTL_TAB[i]) begin
      xfer(CTL_TAB[i], (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'(xs()));
    end

    wr(ADDR_CTL, 8'h80);
    rd(ADDR_CTL, v);
    `CHK("locked disable", 1'h0, v[CTL_IF_DIS])
    wr(ADDR_CTL, 8'h01);
    wr(ADDR_CTL, 8'h81);
    rd(ADDR_CTL, v);
    `CHK("disable set", 8'h81, v)
    `CHK("roms off", 2'b00, {boot_en, ext_en})
    `CHK("selects off", 3'h7, {rtc_cs_b, flash_cs_b, card_cs_b})
    wr(ADDR_XFER, 8'h5a);
    rd(ADDR_STAT, v);
    `CHK("refused start", 1'h0, v[0])
    wr(ADDR_CTL, 8'h21);
    @(negedge mclk);
    `CHK("external rom", 2'b01, {boot_en, ext_en})
    $display("test disable done");
    finish_test();
  end
endmodule
